/* File: design/efu_arbiter.sv */
// Fixed-priority arbiter that admits one function command at a time.
`timescale 1ns/1ps
module efu_arbiter import efu_pkg::*; (
   // Clock and reset
   input  wire logic       clk_i,
   input  wire logic       srst_i,
   input  wire logic       ce_i,
   // Requests and grant
   input  wire logic [3:0] req_i,
   efu_arb_if.arbiter      arb
);
   efu_arb_type q;
   efu_arb_type d;

   always_comb begin
      d = q;
      d.gnt = 1'b0;
      if (arb.idle && !q.gnt && (req_i != 4'h0)) begin
         d.gnt = 1'b1; // R9
         d.who = pick_req(req_i); // R26
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         q <= '0;
      end else if (ce_i) begin
         q <= d;
      end
   end

   assign arb.gnt = q.gnt;
   assign arb.who = q.who;

   default clocking cb @(posedge clk_i iff ce_i); endclocking
   default disable iff (srst_i);
   a_arb_prio_first: assert property (arb.idle && !q.gnt && req_i[0] |=> arb.gnt && arb.who == 2'h0) // R26
      else $error("Requester zero not granted first.");
   a_arb_single_grant: assert property (arb.gnt |=> !arb.gnt) // R9
      else $error("Grant held longer than one cycle.");
endmodule : efu_arbiter

/* File: design/efu_lock_mem.sv */
// Memory of the 64 interlock bits with a panel port on the low sixteen.
`timescale 1ns/1ps
module efu_lock_mem import efu_pkg::*; (
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        srst_i,
   input  wire logic        ce_i,
   // Command side
   efu_lock_if.mem          lk,
   // Operator panel
   input  wire logic        panel_wr_i,
   input  wire logic [15:0] panel_data_i,
   output logic      [15:0] panel_lamp_o
);
   efu_mem_type q;
   efu_mem_type d;

   always_comb begin
      d = q;
      d.rdata = q.bits[lk.raddr];
      if (panel_wr_i) begin
         d.bits[15:0] = panel_data_i; // R15
      end
      if (lk.we) begin
         d.bits[lk.waddr] = lk.wdata; // R14
      end
      d.lamp = d.bits[15:0]; // R15
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         q <= '0;
      end else if (ce_i) begin
         q <= d;
      end
   end

   assign lk.rdata     = q.rdata;
   assign panel_lamp_o = q.lamp;

   default clocking cb @(posedge clk_i iff ce_i); endclocking
   default disable iff (srst_i);
   a_lock_write_kept: assert property (lk.we |=> q.bits[$past(lk.waddr)] == $past(lk.wdata)) // R14
      else $error("Interlock write not stored.");
   a_panel_lamp_track: assert property (panel_wr_i && !lk.we |=> panel_lamp_o == $past(panel_data_i)) // R15
      else $error("Panel lamps do not follow panel write.");
endmodule : efu_lock_mem

/* File: design/efu_top.sv */
// External function unit: command arbiter, targets, pager and registers.
//
// How it works
// R1: Pager keeps sixteen-bit destination pointer.
// R2: Pager keeps fourteen-bit remaining word count.
// R3: Instruction fetch stalls on pager-held page.
// R4: Loading source pointer starts a pager operation.
// R5: Source pointer load aborts transfer, restarts.
// R6: Busy pager fetches commands and data.
// R7: Nineteen-bit command in, one sense bit out.
// R8: Four requesters, three main plus custom.
// R9: One command finished before next admitted.
// R10: Sense and update are one indivisible step.
// R11: Each page switch serves exactly one bus.
// R12: Wrong-bus page access raises hang error.
// R13: Switch sense and new setting use state.
// R14: Sixty-four interlocks sensed and written together.
// R15: Low sixteen interlocks also on panel.
// R16: Off pager starts only when operative.
// R17: Busy pager may stop or stay busy.
// R18: Indicators sensed, set, cleared by number.
// R19: Any set indicator requests host interrupt.
// R20: Indicators 0,1,3,4 force controller inactive.
// R21: Indicators 5,6 make pager inoperative.
// R22: Indicators 8,9 force controller inactive.
// R23: Source pointer addresses data or commands.
// R24: Finished transfer returns switch, then halts.
// R25: Count decrements per word; zero completes.
// R26: Simultaneous requests granted by fixed priority.
`timescale 1ns/1ps
`include "efu_defines.svh"
module efu_top import efu_pkg::*; (
   // Clock, reset and enable
   input  wire logic             clk_i,
   input  wire logic             srst_i,
   input  wire logic             ce_i,
   // Function command requesters
   input  wire logic [3:0]       req_i,
   input  wire logic [3:0][18:0] cmd_i,
   output logic      [3:0]       done_o,
   output logic      [3:0]       sense_o,
   // Register port
   input  wire logic [7:0]       reg_addr_i,
   input  wire logic [31:0]      reg_wdata_i,
   input  wire logic             reg_wr_i,
   input  wire logic             reg_rd_i,
   output logic      [31:0]      reg_rdata_o,
   // Control memory port of the pager
   output logic                  mem_req_o,
   output logic                  mem_we_o,
   output logic      [15:0]      mem_addr_o,
   output logic      [31:0]      mem_wdata_o,
   input  wire logic [31:0]      mem_rdata_i,
   input  wire logic             mem_ack_i,
   // Page memory accesses from the other buses
   input  wire logic             ibus_req_i,
   input  wire logic [1:0]       ibus_page_i,
   input  wire logic             hbus_req_i,
   input  wire logic [1:0]       hbus_page_i,
   output logic                  ibus_stall_o,
   // Error detectors and system effects
   input  wire logic [15:0]      err_event_i,
   output logic                  host_irq_o,
   output logic                  ap_off_o,
   output logic                  pager_busy_o,
   output logic      [5:0]       port_sw_o,
   // Operator panel
   input  wire logic             panel_wr_i,
   input  wire logic [15:0]      panel_data_i,
   output logic      [15:0]      panel_lamp_o
);
   efu_state_type q;
   efu_state_type d;
   efu_arb_if     arb ();
   efu_lock_if    lck ();
   efu_cls_type   cls;
   logic          pwr_rise;

   assign cls      = efu_cls_type'(q.cmd[`EFU_CLS_MSB:`EFU_CLS_LSB]);
   assign pwr_rise = q.ps2[16] & ~q.pprev;
   assign arb.idle = (q.st == ST_IDLE);

   efu_arbiter u_arb (
      .clk_i  (clk_i),
      .srst_i (srst_i),
      .ce_i   (ce_i),
      .req_i  (req_i),
      .arb    (arb.arbiter)
   );

   efu_lock_mem u_lock (
      .clk_i        (clk_i),
      .srst_i       (srst_i),
      .ce_i         (ce_i),
      .lk           (lck.mem),
      .panel_wr_i   (pwr_rise),
      .panel_data_i (q.ps2[15:0]),
      .panel_lamp_o (panel_lamp_o)
   );

   // The interlock is read when the command is admitted and written in its execute cycle.
   assign lck.raddr = cmd_i[arb.who][5:0];
   assign lck.waddr = q.cmd[5:0];
   assign lck.we    = (q.st == ST_EXEC) && (cls == CLS_LOCK); // R10
   assign lck.wdata = apply_op(lck.rdata, q.cmd); // R14

   always_comb begin
      efu_sw_type  cur;
      efu_sw_type  nw;
      logic        kill;
      logic        start;
      logic        inop;
      logic [15:0] hang;
      cur   = SW_INSTR;
      nw    = SW_KEEP;
      kill  = 1'b0;
      start = 1'b0;
      inop  = 1'b0;
      hang  = 16'h0000;
      d = q;
      d.done  = 4'h0;
      d.sense = 4'h0;
      d.rdata = 32'h0000_0000;
      d.ps1   = {panel_wr_i, panel_data_i};
      d.ps2   = q.ps1;
      d.pprev = q.ps2[16];

      // Register port writes.
      if (reg_wr_i) begin
         if (reg_addr_i == `EFU_ADDR_PUT) begin
            d.put = reg_wdata_i[15:0]; // R1
         end else if (reg_addr_i == `EFU_ADDR_CNT) begin
            d.cnt = reg_wdata_i[13:0]; // R2
         end
      end

      // Register port reads; unmapped offsets read zero.
      if (reg_rd_i) begin
         case (reg_addr_i)
            `EFU_ADDR_PUT:  d.rdata = {16'h0000, q.put};
            `EFU_ADDR_CNT:  d.rdata = {18'h00000, q.cnt};
            `EFU_ADDR_GET:  d.rdata = {16'h0000, q.get};
            `EFU_ADDR_STAT: d.rdata = {18'h00000, q.sw, 2'h0, q.pst, q.irq, q.apoff,
                                       |(q.err & `EFU_ERR_PG_MASK), q.busy};
            `EFU_ADDR_ERR:  d.rdata = {16'h0000, q.err};
            default:        d.rdata = 32'h0000_0000;
         endcase
      end

      // Pager engine: command fetch, source read, destination write.
      if (q.mreq && mem_ack_i) begin
         unique case (q.pst)
            P_OFF: begin
               d.pst = P_OFF;
            end
            P_CMD: begin
               d.get = q.get + 16'h0001; // R23
               if (mem_rdata_i[31] && (mem_rdata_i[13:0] != 14'h0000)) begin
                  d.page = mem_rdata_i[30:29];
                  d.cnt  = mem_rdata_i[13:0];
                  d.sw   = set_sw(q.sw, mem_rdata_i[30:29], SW_PAGER); // R11
                  d.pst  = P_SRC;
               end else begin
                  d.pst = P_OFF;
               end
            end
            P_SRC: begin
               d.data = mem_rdata_i; // R6
               d.get  = q.get + 16'h0001; // R23
               d.pst  = P_DST;
            end
            P_DST: begin
               d.put = q.put + 16'h0001; // R1
               d.cnt = q.cnt - 14'h0001; // R25
               if (q.cnt == 14'h0001) begin
                  d.sw  = set_sw(q.sw, q.page, SW_INSTR); // R24
                  d.pst = P_OFF;
               end else begin
                  d.pst = P_SRC;
               end
            end
         endcase
      end

      // Wrong-bus accesses to a page memory.
      if (hbus_req_i && (sw_of(q.sw, hbus_page_i) != SW_HOST)) begin
         hang[`EFU_ERR_HBUS] = 1'b1; // R12
      end
      if (ibus_req_i && (sw_of(q.sw, ibus_page_i) == SW_HOST)) begin
         hang[`EFU_ERR_IBUS] = 1'b1; // R12
      end

      // Function command sequencing.
      unique case (q.st)
         ST_IDLE: begin
            if (arb.gnt) begin
               d.st  = ST_EXEC; // R9
               d.who = arb.who; // R8
               d.cmd = cmd_i[arb.who]; // R7
            end
         end
         ST_EXEC: begin
            d.st = ST_GAP;
            d.done[q.who] = 1'b1; // R7
            unique case (cls)
               CLS_PSW: begin
                  if (q.cmd[5:0] < `EFU_PAGES) begin
                     cur = sw_of(q.sw, q.cmd[1:0]);
                     d.sense[q.who] = (cur == efu_sw_type'(q.cmd[15:14])); // R13
                     unique case (cur)
                        SW_INSTR: nw = efu_sw_type'(q.cmd[9:8]);
                        SW_PAGER: nw = efu_sw_type'(q.cmd[11:10]);
                        SW_HOST:  nw = efu_sw_type'(q.cmd[13:12]);
                        SW_KEEP:  nw = SW_KEEP;
                     endcase
                     if (nw != SW_KEEP) begin
                        d.sw = set_sw(d.sw, q.cmd[1:0], nw); // R13
                     end
                  end
               end
               CLS_LOCK: begin
                  d.sense[q.who] = lck.rdata; // R14
               end
               CLS_PGST: begin
                  d.sense[q.who] = q.busy;
                  if (!q.busy && q.cmd[`EFU_OP_SET]) begin
                     start = 1'b1; // R16
                  end
                  if (q.busy && q.cmd[`EFU_OP_CLR]) begin
                     kill = 1'b1; // R17
                  end
               end
               CLS_ERR: begin
                  d.sense[q.who] = q.err[q.cmd[3:0]]; // R18
                  d.err[q.cmd[3:0]] = apply_op(q.err[q.cmd[3:0]], q.cmd); // R18
               end
               CLS_GET: begin
                  d.sense[q.who] = q.busy;
                  d.get = q.cmd[15:0]; // R4
                  kill  = q.busy; // R5
                  start = 1'b1; // R4
               end
               CLS_PUT: begin
                  d.put = q.cmd[15:0]; // R1
               end
               CLS_CNT: begin
                  d.cnt = q.cmd[13:0]; // R2
               end
               CLS_SPR: begin
                  d.sense[q.who] = 1'b0;
               end
            endcase
         end
         ST_GAP: begin
            d.st = ST_IDLE;
         end
         default: begin
            d.st = ST_IDLE;
         end
      endcase

      // Detector events set indicators after any clear in the same cycle.
      d.err = d.err | err_event_i | hang; // R18
      inop  = |(d.err & `EFU_ERR_PG_MASK); // R21
      if (inop) begin
         kill = 1'b1; // R21
      end
      if (kill && ((d.pst == P_SRC) || (d.pst == P_DST))) begin
         d.sw = set_sw(d.sw, d.page, SW_INSTR); // R5
      end
      if (kill) begin
         d.pst = P_OFF; // R17
      end
      if (start && !inop) begin
         d.pst = P_CMD; // R16
      end

      d.busy  = (d.pst != P_OFF);
      d.mreq  = (d.pst != P_OFF); // R6
      d.mwe   = (d.pst == P_DST);
      d.maddr = (d.pst == P_DST) ? d.put : d.get; // R23
      d.irq   = (d.err != 16'h0000); // R19
      d.apoff = |(d.err & `EFU_ERR_AP_MASK); // R20 R22
      d.stall = ibus_req_i && (sw_of(d.sw, ibus_page_i) == SW_PAGER); // R3
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         q <= '0;
      end else if (ce_i) begin
         q <= d;
      end
   end

   assign done_o       = q.done;
   assign sense_o      = q.sense;
   assign reg_rdata_o  = q.rdata;
   assign mem_req_o    = q.mreq;
   assign mem_we_o     = q.mwe;
   assign mem_addr_o   = q.maddr;
   assign mem_wdata_o  = q.data;
   assign ibus_stall_o = q.stall;
   assign host_irq_o   = q.irq;
   assign ap_off_o     = q.apoff;
   assign pager_busy_o = q.busy;
   assign port_sw_o    = q.sw;

   default clocking cb @(posedge clk_i iff ce_i); endclocking
   default disable iff (srst_i);

   sequence s_admit;
      arb.gnt ##1 (q.st == ST_EXEC);
   endsequence
   sequence s_last_word;
      (q.pst == P_DST) && q.mreq && mem_ack_i && (q.cnt == 14'h0001) && (q.st != ST_EXEC);
   endsequence

   a_done_after_grant: assert property (s_admit |=> $onehot(done_o) ##1 (done_o == 4'h0)) // R9
      else $error("Command not answered exactly once.");
   a_no_grant_busy: assert property ((q.st != ST_IDLE) |-> !arb.gnt) // R9
      else $error("Second command admitted during execution.");
   a_irq_on_event: assert property ((err_event_i != 16'h0000) |=> host_irq_o) // R19
      else $error("Error event without host interrupt.");
   a_ap_off_event: assert property (err_event_i[0] || err_event_i[4] |=> ap_off_o) // R20
      else $error("Controller not forced inactive.");
   a_ap_off_parity: assert property (err_event_i[8] || err_event_i[9] |=> ap_off_o) // R22
      else $error("Parity error left controller active.");
   a_pager_inop: assert property (err_event_i[5] || err_event_i[6] |=> !pager_busy_o) // R21
      else $error("Inoperative pager still busy.");
   a_stall_cause: assert property (ibus_stall_o |-> sw_of(q.sw, $past(ibus_page_i)) == SW_PAGER) // R3
      else $error("Fetch stalled on a page the pager does not hold.");
   a_count_step: assert property ((q.pst == P_DST) && q.mreq && mem_ack_i && (q.cnt > 14'h0001)
      && (q.st != ST_EXEC) && (err_event_i == 16'h0000) |=> q.cnt == $past(q.cnt) - 14'h0001) // R25
      else $error("Word count did not step down.");
   a_finish_return: assert property (s_last_word |=> (sw_of(q.sw, q.page) == SW_INSTR) && !pager_busy_o) // R24
      else $error("Finished transfer did not release page.");
   a_get_load_start: assert property ((q.st == ST_EXEC) && (cls == CLS_GET) && (q.err == 16'h0000)
      && (err_event_i == 16'h0000) |=> (q.get == $past(q.cmd[15:0])) && (q.pst == P_CMD)) // R4
      else $error("Source pointer load did not start pager.");
endmodule : efu_top

/* File: shared/efu_defines.svh */
// Register offsets, command fields, reset values and indicator masks.
`ifndef EFU_DEFINES_SVH
`define EFU_DEFINES_SVH
`define EFU_ADDR_PUT     8'h00
`define EFU_ADDR_CNT     8'h04
`define EFU_ADDR_GET     8'h08
`define EFU_ADDR_STAT    8'h0C
`define EFU_ADDR_ERR     8'h10
`define EFU_CLS_MSB      18
`define EFU_CLS_LSB      16
`define EFU_OP_SET       6
`define EFU_OP_CLR       7
`define EFU_RST_PTR      16'h0000
`define EFU_RST_CNT      14'h0000
`define EFU_PAGES        6'h03
`define EFU_ERR_IBUS     4'h4
`define EFU_ERR_HBUS     4'hA
`define EFU_ERR_AP_MASK  16'h031B
`define EFU_ERR_PG_MASK  16'h0060
`endif

/* File: shared/efu_ifs.sv */
// Arbiter and interlock memory connections inside the unit.
`timescale 1ns/1ps
interface efu_arb_if;
   logic       idle;
   logic       gnt;
   logic [1:0] who;
   modport arbiter (input idle, output gnt, who);
   modport ctrl    (output idle, input gnt, who);
endinterface : efu_arb_if

interface efu_lock_if;
   logic [5:0] raddr;
   logic [5:0] waddr;
   logic       we;
   logic       wdata;
   logic       rdata;
   modport mem  (input raddr, waddr, we, wdata, output rdata);
   modport ctrl (output raddr, waddr, we, wdata, input rdata);
endinterface : efu_lock_if

/* File: shared/efu_pkg.sv */
// Types and helper functions of the external function unit.
`include "efu_defines.svh"
package efu_pkg;
   typedef enum logic [2:0] {
      CLS_PSW  = 3'h0,
      CLS_LOCK = 3'h1,
      CLS_PGST = 3'h2,
      CLS_ERR  = 3'h3,
      CLS_GET  = 3'h4,
      CLS_PUT  = 3'h5,
      CLS_CNT  = 3'h6,
      CLS_SPR  = 3'h7
   } efu_cls_type;
   typedef enum logic [1:0] {
      SW_INSTR = 2'h0,
      SW_PAGER = 2'h1,
      SW_HOST  = 2'h2,
      SW_KEEP  = 2'h3
   } efu_sw_type;
   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_EXEC = 2'h1,
      ST_GAP  = 2'h2
   } efu_st_type;
   typedef enum logic [1:0] {
      P_OFF = 2'h0,
      P_CMD = 2'h1,
      P_SRC = 2'h2,
      P_DST = 2'h3
   } efu_pst_type;
   typedef struct packed {
      efu_st_type  st;
      efu_pst_type pst;
      logic [1:0]  who;
      logic [18:0] cmd;
      logic [15:0] get;
      logic [15:0] put;
      logic [13:0] cnt;
      logic [1:0]  page;
      logic [5:0]  sw;
      logic [15:0] err;
      logic [3:0]  done;
      logic [3:0]  sense;
      logic [31:0] rdata;
      logic [31:0] data;
      logic        mreq;
      logic        mwe;
      logic [15:0] maddr;
      logic        stall;
      logic        irq;
      logic        apoff;
      logic        busy;
      logic [16:0] ps1;
      logic [16:0] ps2;
      logic        pprev;
   } efu_state_type;
   typedef struct packed {
      logic       gnt;
      logic [1:0] who;
   } efu_arb_type;
   typedef struct packed {
      logic [63:0] bits;
      logic        rdata;
      logic [15:0] lamp;
   } efu_mem_type;

   // Returns the bus that a page switch serves; absent pages read as instruction.
   function automatic efu_sw_type sw_of(input logic [5:0] sw, input logic [1:0] pg);
      case (pg)
         2'h0:    sw_of = efu_sw_type'(sw[1:0]);
         2'h1:    sw_of = efu_sw_type'(sw[3:2]);
         2'h2:    sw_of = efu_sw_type'(sw[5:4]);
         default: sw_of = SW_INSTR;
      endcase
   endfunction : sw_of

   function automatic logic [5:0] set_sw(input logic [5:0] sw, input logic [1:0] pg,
                                         input efu_sw_type v);
      set_sw = sw;
      case (pg)
         2'h0:    set_sw[1:0] = v;
         2'h1:    set_sw[3:2] = v;
         2'h2:    set_sw[5:4] = v;
         default: set_sw = sw;
      endcase
   endfunction : set_sw

   // Set wins over clear; with neither bit the old value is kept.
   function automatic logic apply_op(input logic old, input logic [18:0] cmd);
      apply_op = cmd[`EFU_OP_SET] | (old & ~cmd[`EFU_OP_CLR]);
   endfunction : apply_op

   function automatic logic [1:0] pick_req(input logic [3:0] req);
      if (req[0]) pick_req = 2'h0;
      else if (req[1]) pick_req = 2'h1;
      else if (req[2]) pick_req = 2'h2;
      else pick_req = 2'h3;
   endfunction : pick_req
endpackage : efu_pkg

/* File: tb/efu_mem_model.sv */
// Control memory model that answers the pager after a chosen latency.
`timescale 1ns/1ps
module efu_mem_model (
   // Clock and latency
   input  wire logic        clk_i,
   input  wire logic [3:0]  lat_i,
   // Pager memory port
   input  wire logic        mem_req_i,
   input  wire logic        mem_we_i,
   input  wire logic [15:0] mem_addr_i,
   input  wire logic [31:0] mem_wdata_i,
   output logic      [31:0] mem_rdata_o,
   output logic             mem_ack_o
);
   logic [31:0] mem [0:255];
   logic [3:0]  wait_q;
   logic [15:0] addr_q;
   initial begin
      foreach (mem[i]) mem[i] = 32'h0;
      wait_q = 4'h0;
      addr_q = 16'h0;
      mem_ack_o = 1'b0;
      mem_rdata_o = 32'h0;
   end
   // Data lines toggle except when a read is answered; a re-aimed request restarts its wait.
   always @(posedge clk_i) begin
      mem_ack_o <= 1'b0;
      mem_rdata_o <= ~mem_rdata_o;
      addr_q <= mem_addr_i;
      if (!mem_req_i || mem_ack_o || mem_addr_i !== addr_q) begin
         wait_q <= 4'h0;
      end else if (wait_q < lat_i) begin
         wait_q <= wait_q + 4'h1;
      end else begin
         wait_q <= 4'h0;
         mem_ack_o <= 1'b1;
         if (mem_we_i) mem[mem_addr_i[7:0]] <= mem_wdata_i;
         else mem_rdata_o <= mem[mem_addr_i[7:0]];
      end
   end
endmodule : efu_mem_model

/* File: tb/tb.sv */
// Self-checking bench of the external function unit.
`timescale 1ns/1ps
module tb;
   localparam logic [15:0] ap_mask = 16'h031B;
   localparam logic [15:0] pg_mask = 16'h0060;
   logic             clk_i, srst_i, reg_wr_i, reg_rd_i, mem_req_o, mem_we_o, mem_ack_i;
   logic             ibus_req_i, hbus_req_i, ibus_stall_o, host_irq_o, ap_off_o;
   logic             pager_busy_o, panel_wr_i;
   logic [3:0]       req_i, done_o, sense_o, mem_lat;
   logic [3:0][18:0] cmd_i;
   logic [7:0]       reg_addr_i, ord;
   logic [31:0]      reg_wdata_i, reg_rdata_o, mem_wdata_o, mem_rdata_i;
   logic [15:0]      mem_addr_o, err_event_i, panel_data_i, panel_lamp_o;
   logic [1:0]       ibus_page_i, hbus_page_i;
   logic [5:0]       port_sw_o;
   int               num_errors, compares, cycles;
   efu_top uut (
      .clk_i(clk_i), .srst_i(srst_i), .ce_i(1'b1), .req_i(req_i), .cmd_i(cmd_i),
      .done_o(done_o), .sense_o(sense_o), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
      .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
      .mem_req_o(mem_req_o), .mem_we_o(mem_we_o), .mem_addr_o(mem_addr_o),
      .mem_wdata_o(mem_wdata_o), .mem_rdata_i(mem_rdata_i), .mem_ack_i(mem_ack_i),
      .ibus_req_i(ibus_req_i), .ibus_page_i(ibus_page_i), .hbus_req_i(hbus_req_i),
      .hbus_page_i(hbus_page_i), .ibus_stall_o(ibus_stall_o), .err_event_i(err_event_i),
      .host_irq_o(host_irq_o), .ap_off_o(ap_off_o), .pager_busy_o(pager_busy_o),
      .port_sw_o(port_sw_o), .panel_wr_i(panel_wr_i), .panel_data_i(panel_data_i),
      .panel_lamp_o(panel_lamp_o)
   );
   efu_mem_model u_mem (
      .clk_i(clk_i), .lat_i(mem_lat), .mem_req_i(mem_req_o), .mem_we_i(mem_we_o),
      .mem_addr_i(mem_addr_o), .mem_wdata_i(mem_wdata_o), .mem_rdata_o(mem_rdata_i),
      .mem_ack_o(mem_ack_i)
   );
   initial begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end
   task automatic report_and_stop();
      $display("compares %0d mismatches %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : report_and_stop
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         report_and_stop();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge clk_i);
      reg_wr_i <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk_i);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge clk_i);
      reg_rd_i <= 1'b0;
      #1;
      chk(reg_rdata_o, exp);
   endtask : rd
   task automatic cmd(input int k, input logic [18:0] c, input logic s);
      int n;
      @(posedge clk_i);
      req_i[k] <= 1'b1;
      cmd_i[k] <= c;
      n = 0;
      do begin
         @(posedge clk_i);
         #1;
         n++;
      end while (done_o[k] !== 1'b1 && n < 40);
      chk({done_o[k], sense_o[k]}, {1'b1, s});
      @(posedge clk_i);
      req_i[k] <= 1'b0;
      repeat (2) @(posedge clk_i);
   endtask : cmd
   task automatic arb_one(input int k);
      cmd(k, {3'h1, 16'h0060 | 16'(k)}, 1'b0);
      ord = {ord[5:0], 2'(k)};
   endtask : arb_one
   task automatic acc(input logic h, input logic [1:0] pg);
      @(posedge clk_i);
      ibus_req_i <= !h;
      hbus_req_i <= h;
      ibus_page_i <= pg;
      hbus_page_i <= pg;
      @(posedge clk_i);
      ibus_req_i <= 1'b0;
      hbus_req_i <= 1'b0;
      #1;
   endtask : acc
   task automatic wait_for(input logic [5:0] sw, input logic busy);
      int n;
      n = 0;
      while ((port_sw_o !== sw || pager_busy_o !== busy) && n < 400) begin
         @(posedge clk_i);
         #1;
         n++;
      end
      chk({port_sw_o, pager_busy_o}, {sw, busy});
   endtask : wait_for
   initial begin
      {req_i, cmd_i, reg_addr_i, reg_wdata_i, reg_wr_i, reg_rd_i, ord} = '0;
      {ibus_req_i, ibus_page_i, hbus_req_i, hbus_page_i, err_event_i} = '0;
      {panel_wr_i, panel_data_i, num_errors, compares, cycles} = '0;
      srst_i = 1'b1;
      mem_lat = 4'h6;
      repeat (2) @(posedge clk_i);
      srst_i <= 1'b0;
      for (int a = 0; a < 36; a += 4) rd(8'(a), 32'h0);
      wr(8'h00, 32'hFFFFFFFF);
      rd(8'h00, 32'h0000FFFF);
      wr(8'h04, 32'hFFFFFFFF);
      rd(8'h04, 32'h00003FFF);
      wr(8'h08, 32'h00001234);
      rd(8'h08, 32'h0);
      $display("test registers done");
      cmd(0, {3'h1, 16'h007F}, 1'b0);
      cmd(1, {3'h1, 16'h00BF}, 1'b1);
      cmd(2, {3'h1, 16'h003F}, 1'b0);
      cmd(3, {3'h1, 16'h0045}, 1'b0);
      cmd(3, {3'h1, 16'h0050}, 1'b0);
      chk(panel_lamp_o, 16'h0020);
      panel_data_i <= 16'h0004;
      panel_wr_i <= 1'b1;
      repeat (8) @(posedge clk_i);
      panel_wr_i <= 1'b0;
      #1;
      chk(panel_lamp_o, 16'h0004);
      cmd(0, {3'h1, 16'h0002}, 1'b1);
      fork
         arb_one(3);
         arb_one(2);
         arb_one(1);
         arb_one(0);
      join
      chk(ord, 8'h1B);
      $display("test interlocks done");
      for (int i = 0; i < 10; i++) begin
         if (i != 7) begin
            cmd(2, {3'h3, 16'h0040 | 16'(i)}, 1'b0);
            rd(8'h0C, {28'h0, 1'b1, ap_mask[i], pg_mask[i], 1'b0});
            cmd(2, {3'h3, 16'h0080 | 16'(i)}, 1'b1);
            chk({host_irq_o, ap_off_o}, 2'h0);
         end
      end
      @(posedge clk_i);
      err_event_i <= 16'h0004;
      @(posedge clk_i);
      err_event_i <= 16'h0;
      cmd(3, {3'h3, 16'h0002}, 1'b1);
      chk({host_irq_o, ap_off_o}, 2'h2);
      cmd(3, {3'h3, 16'h0082}, 1'b1);
      $display("test indicators done");
      cmd(2, {3'h0, 16'h3E00}, 1'b1);
      chk(port_sw_o, 6'h02);
      acc(1'b1, 2'h0);
      acc(1'b0, 2'h0);
      #8;
      chk({host_irq_o, ap_off_o}, 2'h3);
      cmd(2, {3'h0, 16'h7F00}, 1'b0);
      cmd(2, {3'h0, 16'h8F00}, 1'b1);
      cmd(2, {3'h0, 16'h3E03}, 1'b0);
      chk(port_sw_o, 6'h00);
      cmd(2, {3'h3, 16'h0084}, 1'b1);
      acc(1'b1, 2'h1);
      #8;
      chk({host_irq_o, ap_off_o}, 2'h2);
      cmd(2, {3'h3, 16'h008A}, 1'b1);
      $display("test switches done");
      wr(8'h00, 32'h00000040);
      u_mem.mem[8'h10] = 32'hA0000003;
      for (int i = 0; i < 3; i++) u_mem.mem[8'h11 + i] = 32'h5A000000 + i;
      cmd(0, {3'h4, 16'h0010}, 1'b0);
      wait_for(6'h04, 1'b1);
      acc(1'b0, 2'h1);
      chk(ibus_stall_o, 1'b1);
      wait_for(6'h00, 1'b0);
      for (int i = 0; i < 3; i++) chk(u_mem.mem[8'h40 + i], 32'h5A000000 + i);
      rd(8'h00, 32'h00000043);
      rd(8'h04, 32'h0);
      u_mem.mem[8'h20] = 32'hC0000064;
      u_mem.mem[8'h30] = 32'hA0000001;
      cmd(0, {3'h4, 16'h0020}, 1'b0);
      wait_for(6'h10, 1'b1);
      cmd(1, {3'h4, 16'h0030}, 1'b1);
      wait_for(6'h04, 1'b1);
      wait_for(6'h00, 1'b0);
      $display("test transfers done");
      cmd(2, {3'h3, 16'h0045}, 1'b0);
      cmd(2, {3'h2, 16'h0040}, 1'b0);
      #16;
      chk({pager_busy_o, mem_req_o}, 2'h0);
      cmd(2, {3'h3, 16'h0085}, 1'b1);
      mem_lat <= 4'hF;
      cmd(2, {3'h2, 16'h0040}, 1'b0);
      chk({pager_busy_o, mem_req_o}, 2'h3);
      cmd(1, {3'h2, 16'h0080}, 1'b1);
      cmd(1, {3'h2, 16'h0000}, 1'b0);
      $display("test pager state done");
      report_and_stop();
   end
endmodule : tb
